//--- core/orcr_pkg.sv
// orcr_pkg: constants and types shared by the output regulation command registers
// assumes a 50 MHz MCLK; bus commands arrive on a two-wire serial slave port
package orcr_pkg;
    // bus addressing
    localparam logic [6:0] DEV_ADDR = 7'h18; // 0x30 write, 0x31 read
    // command bytes as sent, odd parity already in bit 7
    localparam logic [7:0] CMD_VO_EN = 8'h0E;
    localparam logic [7:0] CMD_VSET = 8'h10;
    localparam logic [7:0] CMD_CDC = 8'h16;
    localparam logic [7:0] CMD_KNEE = 8'h1A;
    localparam logic [7:0] CMD_TSEL = 8'h2A;
    localparam logic [7:0] CMD_PTR = 8'h80;
    localparam logic [7:0] CMD_FAST = 8'h8C;
    localparam logic [7:0] CMD_CC = 8'h98;
    localparam logic [7:0] CMD_RESP = 8'hA8;
    // read pointer targets
    localparam logic [7:0] PTR_STATUS = 8'h14;
    localparam logic [7:0] PTR_AVG = 8'h1A;
    localparam int READY_BIT = 14;
    localparam int UV_BIT = 1;
    // reset values
    localparam logic [13:0] VSET_RST = 14'h01F4; // 5 V at 10 mV/lsb
    localparam logic [7:0] CC_RST = 8'h80;
    localparam logic [7:0] KNEE_RST = 8'hF0; // 24 V at 100 mV/lsb
    localparam logic [3:0] CDC_RST = 4'h0;
    localparam logic [1:0] TSEL_RST = 2'h0;
    localparam logic [1:0] RESP_RST = 2'h0;
    // legal ranges
    localparam logic [13:0] VSET_MIN = 14'h012C; // 3 V
    localparam logic [13:0] VSET_MAX = 14'h0960; // 24 V
    localparam logic [7:0] CC_MIN = 8'h19; // 20 %
    localparam logic [7:0] CC_MAX = 8'h80; // 100 %
    localparam logic [7:0] KNEE_MIN = 8'h1E; // 3 V
    localparam logic [7:0] KNEE_MAX = 8'hF0; // 24 V, no power region
    localparam logic [3:0] CDC_MAX = 4'hC; // 600 mV
    localparam logic [9:0] CDC_STEP_MV = 10'h032; // 50 mV
    localparam logic [10:0] KNEE_SCALE = 11'h500; // 100mV->10mV times 128
    // fault responses
    localparam logic [1:0] RESP_NONE = 2'h0;
    localparam logic [1:0] RESP_AR = 2'h1;
    localparam logic [1:0] RESP_LO = 2'h2;
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam logic [3:0] VI_GAP_MS = 4'hA; // set-point write spacing
    localparam logic [6:0] PLT_MIN_MS = 7'h08; // shortest peak load time
    // bus engine states, gray along idle-rx-ack-tx-rack
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_RX = 3'b001,
        BUS_ACK = 3'b011,
        BUS_TX = 3'b010,
        BUS_RACK = 3'b110
    } orcr_bus_e;
    // regulation region
    typedef enum logic [1:0] {
        REG_CV = 2'b00,
        REG_CP = 2'b01,
        REG_CC = 2'b11
    } orcr_region_e;
endpackage

//--- core/orcr_top.sv
// orcr_top: serial-bus command registers and regulation limit logic
// assumes SCL/SDA pins with external pull-ups, a same-clock current sampler
// and a core that tells when it can accept commands
//
// Notes on behaviour
// R1: host checks ready flag before bus traffic
// R2: ready read via pointer 0x80 then bit 14
// R3: ready flag is 1 only when commands accepted
// R4: 0x30 write, 0x31 read, command, low, high
// R5: command byte carries odd parity in bit 7
// R6: voltage set point 3-24 V, 10 mV/lsb
// R7: voltage set point resets to 5 V
// R8: current limit codes 25 to 128
// R9: full scale is 32 mV sense drop
// R10: power limit is knee times full-scale current
// R11: region moves CV, then CP, then CC
// R12: knee at 24 V removes power region
// R13: lower current limit keeps power limit unchanged
// R14: cable compensation code 0-12, 50 mV steps
// R15: compensation scales linearly with load current
// R16: shorted sense input: no compensation, no CC
// R17: voltage-only mode makes limit an overload threshold
// R18: overload starts peak timer 8/16/32/64 ms
// R19: persisting overload applies selected fault response
// R20: response resets to none, timer to 8 ms
// R21: voltage-only mode keeps undervoltage protection active
// R22: CC uses averaged current, not instant sample
// R23: average is mean of last 16 samples
// R24: V/I writes spaced 10 ms unless fast set
// R25: data words failing parity are discarded
// R26: out-of-range set points clamp to limits
`timescale 1ns/1ps
module orcr_top #(
    parameter int MS_CYC = orcr_pkg::MS_CYCLES // cycles per millisecond
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic READY_IN,
    input wire logic UV_FLAG,
    input wire logic SENSE_SHORT,
    input wire logic SENSE_VALID,
    input wire logic [7:0] SENSE_SAMPLE,
    output logic [13:0] VSET,
    output logic [7:0] CC_LIMIT,
    output logic [7:0] KNEE,
    output logic [9:0] CDC_MV,
    output orcr_pkg::orcr_region_e REGION,
    output logic [7:0] AVG_CURRENT,
    output logic UV_FORCE,
    output logic FAULT_AR,
    output logic FAULT_LO,
    output logic READY
);
    import orcr_pkg::*;

    localparam int MSW = $clog2(MS_CYC);
    localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYC - 1);

    // all state of the block
    typedef struct packed {
        logic [2:0] scl_sy; // three-stage pin synchroniser
        logic [2:0] sda_sy;
        logic scl_f; // filtered pin levels
        logic sda_f;
        orcr_bus_e st;
        logic [3:0] cnt; // bit counter
        logic [1:0] idx; // byte position in a write
        logic rw; // current transfer is a read
        logic [7:0] sh; // shift register
        logic [7:0] cmd;
        logic [7:0] lo; // held low data byte
        logic [7:0] ptr; // read pointer
        logic [15:0] txw; // word being read out
        logic oe; // pulling SDA low
        logic [13:0] vset;
        logic [7:0] cc;
        logic [7:0] knee;
        logic [3:0] cdc;
        logic vo; // voltage-only mode
        logic [1:0] tsel;
        logic [1:0] resp;
        logic fast; // set-point spacing removed
        logic [MSW-1:0] ms_cnt;
        logic [3:0] vi_gap; // ms left before next V/I write
        logic [6:0] plt; // peak load ms count
        logic [15:0][7:0] samp; // last 16 current samples
        logic [11:0] sum;
        logic short_q;
        logic uv_q;
        orcr_region_e region;
        logic [9:0] cdc_mv;
        logic ar;
        logic latched;
        logic ready;
        logic uv_force;
    } orcr_state_s;

    orcr_state_s r_reg;
    orcr_state_s r_next;

    // clamp helpers for set-point writes
    function automatic logic [13:0] clamp_v(input logic [13:0] d);
        logic [13:0] q;
        q = d;
        if (d < VSET_MIN) begin
            q = VSET_MIN;
        end else if (d > VSET_MAX) begin
            q = VSET_MAX;
        end
        return q;
    endfunction

    function automatic logic [7:0] clamp_b(input logic [13:0] d, input logic [7:0] lo_lim,
                                           input logic [7:0] hi_lim);
        logic [7:0] q;
        q = d[7:0];
        if (d < 14'(lo_lim)) begin
            q = lo_lim;
        end else if (d > 14'(hi_lim)) begin
            q = hi_lim;
        end
        return q;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic scl_ok;
        logic sda_ok;
        logic scl_rise;
        logic scl_fall;
        logic sda_rise;
        logic sda_fall;
        logic tick;
        logic vi_ok;
        logic par_ok;
        logic [13:0] d14;
        logic [7:0] avg;
        logic [7:0] avg_c;
        logic [19:0] p_load;
        logic [19:0] p_lim;
        logic overload;
        logic [6:0] plt_lim;
        logic [16:0] cdc_prod;
        scl_ok = 1'b0;
        sda_ok = 1'b0;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        sda_rise = 1'b0;
        sda_fall = 1'b0;
        tick = 1'b0;
        vi_ok = 1'b0;
        par_ok = 1'b0;
        d14 = '0;
        avg = '0;
        avg_c = '0;
        p_load = '0;
        p_lim = '0;
        overload = 1'b0;
        plt_lim = '0;
        cdc_prod = '0;
        r_next = r_reg;
        r_next.ar = 1'b0;

        // pin filter: a level counts once stages two and three agree
        r_next.scl_sy = {r_reg.scl_sy[1:0], SCL_IN};
        r_next.sda_sy = {r_reg.sda_sy[1:0], SDA_IN};
        scl_ok = (r_reg.scl_sy[1] == r_reg.scl_sy[2]);
        sda_ok = (r_reg.sda_sy[1] == r_reg.sda_sy[2]);
        if (scl_ok) begin
            r_next.scl_f = r_reg.scl_sy[2];
        end
        if (sda_ok) begin
            r_next.sda_f = r_reg.sda_sy[2];
        end
        scl_rise = scl_ok && r_reg.scl_sy[2] && !r_reg.scl_f;
        scl_fall = scl_ok && !r_reg.scl_sy[2] && r_reg.scl_f;
        sda_rise = sda_ok && r_reg.sda_sy[2] && !r_reg.sda_f;
        sda_fall = sda_ok && !r_reg.sda_sy[2] && r_reg.sda_f;

        // millisecond tick and set-point spacing
        tick = (r_reg.ms_cnt == MS_LAST);
        r_next.ms_cnt = tick ? '0 : r_reg.ms_cnt + 1'b1;
        if (tick && r_reg.vi_gap != 4'h0) begin
            r_next.vi_gap = r_reg.vi_gap - 4'h1;
        end
        vi_ok = r_reg.fast || (r_reg.vi_gap == 4'h0); // R24
        d14 = {r_reg.sh[6:0], r_reg.lo[6:0]};
        par_ok = (^r_reg.sh) && (^r_reg.lo); // R25

        // serial bus engine
        case (r_reg.st)
            BUS_RX: begin
                if (scl_rise) begin
                    r_next.sh = {r_reg.sh[6:0], r_reg.sda_f};
                    r_next.cnt = r_reg.cnt + 4'h1;
                end else if (scl_fall && r_reg.cnt == 4'h8) begin
                    r_next.cnt = 4'h0;
                    r_next.st = BUS_ACK;
                    r_next.oe = 1'b1;
                    if (r_reg.idx != 2'h3) begin
                        r_next.idx = r_reg.idx + 2'h1;
                    end
                    case (r_reg.idx)
                        2'h0: begin
                            // address byte: answer only when ready
                            if (r_reg.sh[7:1] != DEV_ADDR || !r_reg.ready) begin // R3
                                r_next.st = BUS_IDLE;
                                r_next.oe = 1'b0;
                            end
                            r_next.rw = r_reg.sh[0]; // R4
                            r_next.txw = '0;
                            if (r_reg.ptr == PTR_STATUS) begin // R2
                                r_next.txw[READY_BIT] = r_reg.ready;
                                r_next.txw[UV_BIT] = r_reg.uv_q;
                            end else if (r_reg.ptr == PTR_AVG) begin
                                r_next.txw[7:0] = r_reg.sum[11:4];
                            end
                        end
                        2'h1: begin
                            // command byte needs odd parity
                            if (!(^r_reg.sh)) begin // R5
                                r_next.st = BUS_IDLE;
                                r_next.oe = 1'b0;
                            end
                            r_next.cmd = r_reg.sh;
                        end
                        2'h2: begin
                            // byte-wide registers commit on first data byte
                            r_next.lo = r_reg.sh;
                            case (r_reg.cmd)
                                CMD_VO_EN: r_next.vo = r_reg.sh[0]; // R17
                                CMD_CDC: r_next.cdc = (r_reg.sh[3:0] > CDC_MAX) ?
                                                      CDC_MAX : r_reg.sh[3:0]; // R14
                                CMD_TSEL: r_next.tsel = r_reg.sh[1:0]; // R18
                                CMD_RESP: r_next.resp = r_reg.sh[1:0]; // R19
                                CMD_FAST: r_next.fast = r_reg.sh[0]; // R24
                                CMD_PTR: r_next.ptr = r_reg.sh; // R2
                                default: begin
                                end
                            endcase
                        end
                        default: begin
                            // word registers: low then high byte, parity checked
                            if (par_ok) begin // R25
                                case (r_reg.cmd)
                                    CMD_VSET: begin
                                        if (vi_ok) begin // R24
                                            r_next.vset = clamp_v(d14); // R6 R26
                                            r_next.vi_gap = VI_GAP_MS;
                                        end
                                    end
                                    CMD_CC: begin
                                        if (vi_ok) begin // R24
                                            r_next.cc = clamp_b(d14, CC_MIN, CC_MAX); // R8 R26
                                            r_next.vi_gap = VI_GAP_MS;
                                        end
                                    end
                                    CMD_KNEE: r_next.knee = clamp_b(d14, KNEE_MIN,
                                                                   KNEE_MAX); // R10 R26
                                    default: begin
                                    end
                                endcase
                            end
                        end
                    endcase
                end
            end
            BUS_ACK: begin
                // release acknowledge, then read out or receive on
                if (scl_fall) begin
                    r_next.cnt = 4'h0;
                    if (r_reg.rw) begin
                        r_next.sh = r_reg.txw[7:0]; // R4
                        r_next.oe = ~r_reg.txw[7];
                        r_next.st = BUS_TX;
                    end else begin
                        r_next.oe = 1'b0;
                        r_next.st = BUS_RX;
                    end
                end
            end
            BUS_TX: begin
                // shift out msb first, change data on falling edges
                if (scl_rise) begin
                    r_next.cnt = r_reg.cnt + 4'h1;
                end else if (scl_fall) begin
                    if (r_reg.cnt == 4'h8) begin
                        r_next.oe = 1'b0;
                        r_next.cnt = 4'h0;
                        r_next.st = BUS_RACK;
                    end else begin
                        r_next.sh = {r_reg.sh[6:0], 1'b0};
                        r_next.oe = ~r_reg.sh[6];
                    end
                end
            end
            BUS_RACK: begin
                // master nack ends the read, ack brings the high byte
                if (scl_rise && r_reg.sda_f) begin
                    r_next.st = BUS_IDLE;
                end else if (scl_fall) begin
                    r_next.sh = r_reg.txw[15:8];
                    r_next.oe = ~r_reg.txw[15];
                    r_next.txw = {r_reg.txw[7:0], r_reg.txw[15:8]};
                    r_next.st = BUS_TX;
                end
            end
            default: begin
                r_next.oe = 1'b0;
            end
        endcase
        // start and stop override the engine
        if (sda_fall && r_reg.scl_f) begin
            r_next.st = BUS_RX;
            r_next.idx = 2'h0;
            r_next.cnt = 4'h0;
            r_next.oe = 1'b0;
        end else if (sda_rise && r_reg.scl_f) begin
            r_next.st = BUS_IDLE;
            r_next.oe = 1'b0;
        end

        // running mean of the last 16 samples
        if (SENSE_VALID) begin
            r_next.samp = {r_reg.samp[14:0], SENSE_SAMPLE}; // R23
            r_next.sum = r_reg.sum + 12'(SENSE_SAMPLE) - 12'(r_reg.samp[15]); // R23
        end
        avg = r_reg.sum[11:4]; // R22
        avg_c = (avg > CC_MAX) ? CC_MAX : avg;

        // region: power limit uses full scale, not the current limit
        p_load = 20'(avg) * 20'(r_reg.vset); // R10 R13
        p_lim = 20'(r_reg.knee) * 20'(KNEE_SCALE); // R9 R10
        r_next.region = REG_CV;
        if (!r_reg.short_q && !r_reg.vo) begin // R16 R17
            if (avg >= r_reg.cc) begin
                r_next.region = REG_CC; // R11 R22
            end else if (r_reg.knee != KNEE_MAX && p_load >= p_lim) begin // R12
                r_next.region = REG_CP; // R11
            end
        end

        // cable compensation grows linearly to full scale
        cdc_prod = 17'(10'(r_reg.cdc) * CDC_STEP_MV) * 17'(avg_c); // R15
        r_next.cdc_mv = r_reg.short_q ? 10'h000 : cdc_prod[16:7]; // R15 R16

        // peak load timer in voltage-only mode
        overload = r_reg.vo && (avg > r_reg.cc) && !r_reg.latched; // R17
        plt_lim = PLT_MIN_MS << r_reg.tsel; // R18 R20
        if (!overload) begin
            r_next.plt = 7'h00;
        end else if (r_reg.plt >= plt_lim) begin
            // timer ran out while overload held
            if (r_reg.resp == RESP_AR) begin // R19
                r_next.ar = 1'b1;
                r_next.plt = 7'h00;
            end else if (r_reg.resp == RESP_LO) begin // R19
                r_next.latched = 1'b1;
            end
        end else if (tick) begin
            r_next.plt = r_reg.plt + 7'h01; // R18
        end

        r_next.short_q = SENSE_SHORT;
        r_next.uv_q = UV_FLAG;
        r_next.uv_force = r_reg.vo; // R21
        r_next.ready = READY_IN && !r_reg.latched; // R3

        // synchronous reset values
        if (RST) begin
            r_next = '0;
            r_next.scl_sy = 3'b111;
            r_next.sda_sy = 3'b111;
            r_next.scl_f = 1'b1;
            r_next.sda_f = 1'b1;
            r_next.st = BUS_IDLE;
            r_next.ptr = PTR_STATUS;
            r_next.vset = VSET_RST; // R7
            r_next.cc = CC_RST;
            r_next.knee = KNEE_RST;
            r_next.cdc = CDC_RST;
            r_next.tsel = TSEL_RST; // R20
            r_next.resp = RESP_RST; // R20
            r_next.region = REG_CV;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register, frozen while CE and RST are both low
    always_ff @(posedge MCLK) begin
        if (RST || CE) begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register, except SDA_OUT which is tied low
    assign SDA_OUT = 1'b0;
    assign SDA_OE = r_reg.oe;
    assign VSET = r_reg.vset;
    assign CC_LIMIT = r_reg.cc;
    assign KNEE = r_reg.knee;
    assign CDC_MV = r_reg.cdc_mv;
    assign REGION = r_reg.region;
    assign AVG_CURRENT = r_reg.sum[11:4];
    assign UV_FORCE = r_reg.uv_force;
    assign FAULT_AR = r_reg.ar;
    assign FAULT_LO = r_reg.latched;
    assign READY = r_reg.ready;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    vset_reset_a: assert property ($past(RST) |-> r_reg.vset == VSET_RST) // R7
        else $error("voltage set point not 5 V after reset");
    vset_range_a: assert property (r_reg.vset >= VSET_MIN && r_reg.vset <= VSET_MAX) // R6
        else $error("voltage set point out of range");
    cc_range_a: assert property (r_reg.cc >= CC_MIN && r_reg.cc <= CC_MAX) // R8
        else $error("current limit out of range");
    cdc_range_a: assert property (r_reg.cdc <= CDC_MAX) // R14
        else $error("cable compensation code out of range");
    ready_gate_a: assert property (r_reg.latched |-> ##1 !r_reg.ready) // R3
        else $error("ready reported while latched off");
    no_cp_a: assert property (CE && r_reg.knee == KNEE_MAX |=> r_reg.region != REG_CP) // R12
        else $error("power region with knee at maximum");
    short_sense_a: assert property (CE && r_reg.short_q |=>
                                    r_reg.region == REG_CV && r_reg.cdc_mv == 10'h000) // R16
        else $error("regulation active with shorted sense input");
    vo_no_cc_a: assert property (CE && r_reg.vo |=> r_reg.region != REG_CC) // R17
        else $error("current regulation in voltage-only mode");
    vi_gap_a: assert property (CE && !r_reg.fast && r_reg.vi_gap != 4'h0 |=>
                               $stable(r_reg.vset)) // R24
        else $error("set point changed inside spacing window");
    latch_cause_a: assert property ($rose(r_reg.latched) |->
                                    $past(r_reg.resp) == RESP_LO && $past(r_reg.vo)) // R19
        else $error("latch-off without programmed response");
    uv_force_a: assert property (CE && r_reg.vo |=> r_reg.uv_force) // R21
        else $error("undervoltage protection dropped in voltage-only mode");
endmodule

//--- dv/orcr_i2c_host.sv
// two-wire bus master model for the command port
// assumes the bench builds the pulled-up data wire from all enables
`timescale 1ns/1ps
module orcr_i2c_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // bus idles released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one bus phase, above the 2 clock filter minimum
    task automatic ph();
        repeat (10) @(posedge clk);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        ph();
        sda_pull <= 1'b0;
        ph();
        scl <= 1'b1;
        ph();
        sda_pull <= 1'b1;
        ph();
        scl <= 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        ph();
        sda_pull <= 1'b1;
        ph();
        scl <= 1'b1;
        ph();
        sda_pull <= 1'b0;
        ph();
    endtask
    // byte msb first then ack slot; data moves only while clock low
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            ph();
            sda_pull <= !d[i];
            ph();
            scl <= 1'b1;
            ph();
            q[i] = sda;
            scl <= 1'b0;
        end
    endtask
endmodule

//--- dv/orcr_top_tb.sv
// self-checking bench for the command registers
// assumes the host model drives the bus pins; ms scaled to 200 clocks
`timescale 1ns/1ps
module orcr_top_tb;
    import orcr_pkg::*;
    logic MCLK, RST, READY_IN, UV_FLAG, SENSE_SHORT, SENSE_VALID, scl, pull;
    logic SDA_OUT, SDA_OE, UV_FORCE, FAULT_AR, FAULT_LO, READY;
    logic [7:0] SENSE_SAMPLE, CC_LIMIT, KNEE, AVG_CURRENT;
    logic [13:0] VSET;
    logic [9:0] CDC_MV;
    orcr_region_e REGION;
    int mismatches, n_tests;
    // open-drain data wire with pull-up
    wire sda = !(pull | SDA_OE);
    orcr_top #(.MS_CYC(200)) u_orcr_top (.MCLK(MCLK), .RST(RST), .CE(1'b1),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
        .READY_IN(READY_IN), .UV_FLAG(UV_FLAG), .SENSE_SHORT(SENSE_SHORT),
        .SENSE_VALID(SENSE_VALID), .SENSE_SAMPLE(SENSE_SAMPLE), .VSET(VSET),
        .CC_LIMIT(CC_LIMIT), .KNEE(KNEE), .CDC_MV(CDC_MV), .REGION(REGION),
        .AVG_CURRENT(AVG_CURRENT), .UV_FORCE(UV_FORCE), .FAULT_AR(FAULT_AR),
        .FAULT_LO(FAULT_LO), .READY(READY));
    orcr_i2c_host u_orcr_i2c_host (.clk(MCLK), .sda(sda), .scl(scl), .sda_pull(pull));
    // compare and count
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // write: address, command, data; ok when address and command acked
    task automatic wr(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi,
        input bit two, output logic ok);
        logic [8:0] q;
        u_orcr_i2c_host.start();
        u_orcr_i2c_host.xfer({8'h30, 1'b1}, q);
        ok = !q[0];
        u_orcr_i2c_host.xfer({c, 1'b1}, q);
        ok = ok & !q[0];
        if (ok) begin
            u_orcr_i2c_host.xfer({lo, 1'b1}, q);
            if (two) u_orcr_i2c_host.xfer({hi, 1'b1}, q);
        end
        u_orcr_i2c_host.stop();
    endtask
    // status word read through the pointer
    task automatic rd_status(output logic [15:0] w);
        logic [8:0] q;
        logic ok;
        wr(CMD_PTR, PTR_STATUS, 8'h00, 1'b0, ok);
        u_orcr_i2c_host.start();
        u_orcr_i2c_host.xfer({8'h31, 1'b1}, q);
        u_orcr_i2c_host.xfer({8'hFF, 1'b0}, q);
        w[7:0] = q[8:1];
        u_orcr_i2c_host.xfer({8'hFF, 1'b1}, q);
        w[15:8] = q[8:1];
        u_orcr_i2c_host.stop();
    endtask
    // sixteen current samples, refilling the average
    task automatic feed(input logic [7:0] v);
        repeat (16) begin
            SENSE_SAMPLE <= v;
            SENSE_VALID <= 1'b1;
            @(posedge MCLK);
            SENSE_VALID <= 1'b0;
            @(posedge MCLK);
        end
        repeat (3) @(posedge MCLK);
    endtask
    // reset values, ready read, refusal while not ready
    task automatic t_ready();
        logic [15:0] w;
        logic ok;
        chk("vset", 16'(VSET), 16'h01F4);
        chk("cc", 16'(CC_LIMIT), 16'h0080);
        chk("knee", 16'(KNEE), 16'h00F0);
        chk("flt", {11'h000, SDA_OUT, FAULT_AR, FAULT_LO, REGION}, 16'h0000);
        UV_FLAG <= 1'b1;
        rd_status(w);
        chk("status", w, 16'h4002);
        READY_IN <= 1'b0;
        repeat (3) @(posedge MCLK);
        wr(CMD_VSET, 8'h20, 8'h86, 1'b1, ok);
        chk("nack", 16'(ok), 16'h0000);
        READY_IN <= 1'b1;
        repeat (3) @(posedge MCLK);
        $display("test ready done");
    endtask
    // set point, gap, parity, clamp
    task automatic t_vset();
        logic ok;
        wr(CMD_VSET, 8'h20, 8'h86, 1'b1, ok);
        chk("vset", 16'(VSET), 16'h0320);
        wr(CMD_CC, 8'h40, 8'h80, 1'b1, ok);
        chk("gap", 16'(CC_LIMIT), 16'h0080);
        wr(8'h18, 8'h40, 8'h80, 1'b1, ok);
        chk("par", 16'(ok), 16'h0000);
        repeat (1100) @(posedge MCLK);
        wr(CMD_VSET, 8'hA0, 8'h86, 1'b1, ok);
        chk("bad", 16'(VSET), 16'h0320);
        repeat (1100) @(posedge MCLK);
        wr(CMD_VSET, 8'h38, 8'h97, 1'b1, ok);
        chk("clamp", 16'(VSET), 16'h0960);
        $display("test vset done");
    endtask
    // limits, average, compensation, regions
    task automatic t_limits();
        logic ok;
        wr(CMD_FAST, 8'h01, 8'h00, 1'b0, ok);
        wr(CMD_CC, 8'h40, 8'h80, 1'b1, ok);
        chk("cc", 16'(CC_LIMIT), 16'h0040);
        wr(CMD_CC, 8'h46, 8'h80, 1'b1, ok);
        chk("fast", 16'(CC_LIMIT), 16'h0046);
        wr(CMD_KNEE, 8'hD0, 8'h80, 1'b1, ok);
        chk("knee", 16'(KNEE), 16'h0050);
        wr(CMD_CDC, 8'h06, 8'h00, 1'b0, ok);
        feed(8'h80);
        chk("avg", 16'(AVG_CURRENT), 16'h0080);
        chk("cdc", 16'(CDC_MV), 16'h012C);
        chk("rcc", 16'(REGION), 16'(REG_CC));
        feed(8'h32);
        chk("rcp", 16'(REGION), 16'(REG_CP));
        SENSE_SHORT <= 1'b1;
        feed(8'h80);
        chk("short", {6'h00, CDC_MV}, 16'h0000);
        chk("rsh", 16'(REGION), 16'(REG_CV));
        SENSE_SHORT <= 1'b0;
        wr(CMD_KNEE, 8'h70, 8'h01, 1'b1, ok);
        feed(8'h32);
        chk("rcv", 16'(REGION), 16'(REG_CV));
        $display("test limits done");
    endtask
    // voltage-only overload timer and responses
    task automatic t_vo();
        logic ok;
        int n;
        feed(8'h80);
        wr(CMD_RESP, 8'h01, 8'h00, 1'b0, ok);
        wr(CMD_TSEL, 8'h00, 8'h00, 1'b0, ok);
        wr(CMD_VO_EN, 8'h01, 8'h00, 1'b0, ok);
        chk("vo", {14'h0000, UV_FORCE, REGION == REG_CV}, 16'h0003);
        for (n = 0; n < 2400 && FAULT_AR !== 1'b1; n++) @(posedge MCLK);
        chk("tmr", 16'(n >= 1300 && n <= 1700), 16'h0001);
        wr(CMD_RESP, 8'h02, 8'h00, 1'b0, ok);
        for (n = 0; n < 2400 && FAULT_LO !== 1'b1; n++) @(posedge MCLK);
        repeat (2) @(posedge MCLK);
        chk("lo", {14'h0000, FAULT_LO, READY}, 16'h0002);
        chk("uv", 16'(UV_FORCE), 16'h0001);
        $display("test vo done");
    endtask
    // counts, verdict, end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // 50 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge MCLK);
        mismatches++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {RST, READY_IN, UV_FLAG, SENSE_SHORT, SENSE_VALID} = 5'b11000;
        SENSE_SAMPLE = 8'h00;
        mismatches = 0;
        n_tests = 0;
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        repeat (3) @(posedge MCLK);
        t_ready();
        t_vset();
        t_limits();
        t_vo();
        tally_and_finish();
    end
endmodule
